// ==== design/ptlm_top.sv ====
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ptlm_top #(
  parameter int MS_CYCLES = ptlm_pkg::MS_CYC
) (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Terminal and keypad pins
  input wire logic ext_trip_pin_in,
  input wire logic enable_pin_in,
  input wire logic stop_key_in,
  input wire logic esc_key_in,
  input wire logic keypad_present_in,
  input wire logic run_pin_in,
  // Fault conditions from drive logic
  input wire logic overload_in,
  input wire logic stall_in,
  input wire logic overvolt_in,
  input wire logic undervolt_in,
  input wire logic overtemp_in,
  // Drive and indication
  output logic power_enable_out,
  output logic trip_active_flag_out,
  output logic [3:0] first_code_out,
  output logic indicator_a_out,
  output logic keypad_msg_out,
  output logic [3:0] keypad_cause_out,
  output logic irq_out
);
  // ******************************
  // Functions
  // ******************************
  // Lowest-index set fault as code, zero if none
  function automatic logic [3:0] code_of(input logic [ptlm_pkg::NF-1:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int k = ptlm_pkg::NF - 1; k >= 0; k--) begin
      if (v[k]) begin
        c = 4'(k + 1);
      end
    end
    return c;
  endfunction

  // Millisecond counter step, saturating
  function automatic logic [15:0] inc16(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // ******************************
  // Pin synchronisers
  // ******************************
  ptlm_sync_if #(.N(ptlm_pkg::NS)) pins ();
  assign pins.raw = {run_pin_in, keypad_present_in, esc_key_in,
                     stop_key_in, enable_pin_in, ext_trip_pin_in};
  ptlm_sync #(.N(ptlm_pkg::NS), .RST_VAL(ptlm_pkg::PIN_IDLE)) u_sync (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .s(pins)
  );

  logic [ptlm_pkg::NS-1:0] pin_prev;
  logic [ptlm_pkg::NS-1:0] pin_rise;
  // Edge history of clean pins
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pin_prev <= ptlm_pkg::PIN_IDLE;
    end else if (ce_in) begin
      pin_prev <= pins.clean;
    end
  end
  assign pin_rise = pins.clean & ~pin_prev;

  // ******************************
  // Registers
  // ******************************
  logic [1:0] ctrl;
  logic [15:0] stall_ms;
  logic [15:0] link_ms;
  logic [15:0] cmd_word;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [ptlm_pkg::NF-1:0] latch;
  logic [ptlm_pkg::NF-1:0] cond;

  // ******************************
  // AHB-Lite slave, zero wait states
  // ******************************
  logic wr_pend;
  logic [7:0] wr_ofs;
  logic addr_ok;
  logic wr_go;
  logic cmd_wr;
  assign addr_ok = hsel_in && hready_in && htrans_in[1];
  assign wr_go = ce_in && wr_pend;
  assign cmd_wr = wr_go && (wr_ofs == ptlm_pkg::OFS_CMD);

  // Address phase capture and read data
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else if (ce_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      wr_pend <= addr_ok && hwrite_in;
      wr_ofs <= haddr_in[7:0];
      hrdata_out <= 32'h0000_0000;
      if (addr_ok && !hwrite_in && haddr_in[31:8] == 24'h000000) begin
        unique case (haddr_in[7:0])
          ptlm_pkg::OFS_CTRL: hrdata_out <= {30'h0, ctrl};
          ptlm_pkg::OFS_STALL: hrdata_out <= {16'h0, stall_ms};
          ptlm_pkg::OFS_LINK: hrdata_out <= {16'h0, link_ms};
          ptlm_pkg::OFS_CMD: hrdata_out <= {16'h0, cmd_word};
          ptlm_pkg::OFS_STAT: hrdata_out <= {7'h0, power_enable_out, cond, latch,
                                             first_code_out, 3'h0, trip_active_flag_out};
          ptlm_pkg::OFS_IRQ: hrdata_out <= {30'h0, irq_stat};
          ptlm_pkg::OFS_MASK: hrdata_out <= {30'h0, irq_mask};
          default: hrdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Writable configuration
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl <= ptlm_pkg::CTRL_RST;
      stall_ms <= ptlm_pkg::STALL_RST;
      link_ms <= ptlm_pkg::LINK_RST;
      cmd_word <= 16'h0000;
      irq_mask <= 2'h0;
    end else if (wr_go) begin
      if (wr_ofs == ptlm_pkg::OFS_CTRL) begin
        ctrl <= hwdata_in[1:0];
      end
      if (wr_ofs == ptlm_pkg::OFS_STALL) begin
        stall_ms <= hwdata_in[15:0];
      end
      if (wr_ofs == ptlm_pkg::OFS_LINK) begin
        link_ms <= hwdata_in[15:0];
      end
      if (cmd_wr) begin
        cmd_word <= hwdata_in[15:0];
      end
      if (wr_ofs == ptlm_pkg::OFS_MASK) begin
        irq_mask <= hwdata_in[1:0];
      end
    end
  end

  // ******************************
  // Millisecond time base
  // ******************************
  logic [31:0] pre_cnt;
  logic ms_tick;
  assign ms_tick = ce_in && (pre_cnt == 32'(MS_CYCLES - 1));
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pre_cnt <= 32'h0000_0000;
    end else if (ce_in) begin
      pre_cnt <= ms_tick ? 32'h0000_0000 : pre_cnt + 32'h0000_0001;
    end
  end

  // ******************************
  // Fault detectors
  // ******************************
  logic [15:0] it_cnt;
  logic [15:0] stall_cnt;
  logic [15:0] link_cnt;

  // Overload, stall and link timers in milliseconds
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      it_cnt <= 16'h0000;
      stall_cnt <= 16'h0000;
      link_cnt <= 16'h0000;
    end else if (ce_in) begin
      if (!overload_in) begin
        it_cnt <= 16'h0000;
      end else if (ms_tick) begin
        it_cnt <= inc16(it_cnt);
      end
      if (!stall_in) begin
        stall_cnt <= 16'h0000;
      end else if (ms_tick) begin
        stall_cnt <= inc16(stall_cnt);
      end
      if (cmd_wr) begin
        link_cnt <= 16'h0000;
      end else if (ms_tick) begin
        link_cnt <= inc16(link_cnt);
      end
    end
  end

  // Present fault conditions
  always_comb begin
    cond = 8'h00;
    cond[ptlm_pkg::F_EXT] = !ctrl[ptlm_pkg::CTRL_EXTDIS] && !pins.clean[ptlm_pkg::S_EXT];
    cond[ptlm_pkg::F_IT] = overload_in && (it_cnt >= ptlm_pkg::IT_MS);
    cond[ptlm_pkg::F_STALL] = stall_in && (stall_cnt > stall_ms);
    cond[ptlm_pkg::F_KPAD] = ctrl[ptlm_pkg::CTRL_LOCAL] && power_enable_out
                             && !pins.clean[ptlm_pkg::S_KPAD];
    cond[ptlm_pkg::F_LINK] = (link_ms != 16'h0000) && (link_cnt >= link_ms);
    cond[ptlm_pkg::F_OVOLT] = overvolt_in;
    cond[ptlm_pkg::F_UVOLT] = undervolt_in;
    cond[ptlm_pkg::F_OTEMP] = overtemp_in;
  end

  // ******************************
  // Trip latch
  // ******************************
  logic clr_ok;
  logic new_trip;
  logic [ptlm_pkg::NF-1:0] next_latch;
  // Stop or enable re-applied, only with every fault gone
  assign clr_ok = (pin_rise[ptlm_pkg::S_STOP] || pin_rise[ptlm_pkg::S_EN])
                  && (cond == 8'h00);
  assign new_trip = (latch == 8'h00) && (cond != 8'h00);
  assign next_latch = clr_ok ? 8'h00 : (latch | cond);

  // Latch, flag and first code
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      latch <= 8'h00;
      trip_active_flag_out <= 1'b0;
      first_code_out <= 4'h0;
    end else if (ce_in) begin
      latch <= next_latch;
      trip_active_flag_out <= (next_latch != 8'h00);
      if (clr_ok) begin
        first_code_out <= 4'h0;
      end else if (new_trip) begin
        first_code_out <= code_of(cond);
      end
    end
  end

  // ******************************
  // Power stage sequencing
  // ******************************
  logic run_armed;
  // A run edge after the trip is gone arms the drive again
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      run_armed <= 1'b0;
      power_enable_out <= 1'b0;
    end else if (ce_in) begin
      if (next_latch != 8'h00) begin
        run_armed <= 1'b0;
      end else if (pin_rise[ptlm_pkg::S_RUN]) begin
        run_armed <= 1'b1;
      end
      power_enable_out <= pins.clean[ptlm_pkg::S_RUN] && pins.clean[ptlm_pkg::S_EN]
                          && (run_armed || pin_rise[ptlm_pkg::S_RUN])
                          && (next_latch == 8'h00);
    end
  end

  // ******************************
  // Keypad indication
  // ******************************
  logic [15:0] flash_cnt;
  // Indicator_a lamp steady when healthy, flashing when trip_active_flag
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      flash_cnt <= 16'h0000;
      indicator_a_out <= 1'b1;
    end else if (ce_in) begin
      if (next_latch == 8'h00) begin
        flash_cnt <= 16'h0000;
        indicator_a_out <= 1'b1;
      end else if (ms_tick) begin
        if (flash_cnt == ptlm_pkg::FLASH_MS - 16'h0001) begin
          flash_cnt <= 16'h0000;
          indicator_a_out <= !indicator_a_out;
        end else begin
          flash_cnt <= flash_cnt + 16'h0001;
        end
      end
    end
  end

  // Trip message, raised by a new trip, closed by stop or escape
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      keypad_msg_out <= 1'b0;
      keypad_cause_out <= 4'h0;
    end else if (ce_in) begin
      if (new_trip) begin
        keypad_msg_out <= 1'b1;
        keypad_cause_out <= code_of(cond);
      end else if (pin_rise[ptlm_pkg::S_STOP] || pin_rise[ptlm_pkg::S_ESC]) begin
        keypad_msg_out <= 1'b0;
      end
    end
  end

  // ******************************
  // Interrupts
  // ******************************
  logic [1:0] irq_set;
  logic [1:0] irq_w1c;
  assign irq_set = {clr_ok && (latch != 8'h00), new_trip};
  assign irq_w1c = (wr_go && wr_ofs == ptlm_pkg::OFS_IRQ) ? hwdata_in[1:0] : 2'h0;
  // Set wins over a clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_stat <= 2'h0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      irq_stat <= (irq_stat & ~irq_w1c) | irq_set;
      irq_out <= (((irq_stat & ~irq_w1c) | irq_set) & irq_mask) != 2'h0;
    end
  end

  // ******************************
  // Assertions
  // ******************************
  AST_TRIP_OFF: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && cond != 8'h00 |=> !power_enable_out && trip_active_flag_out)
    else $error("power stage left on after a trip");
  AST_HOLD: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && trip_active_flag_out && !clr_ok |=> trip_active_flag_out)
    else $error("trip latch dropped without reset");
  AST_TRANSIENT: assert property (@(posedge mclk_in) disable iff (rst_in)
    trip_active_flag_out && $fell(cond != 8'h00) |-> !power_enable_out)
    else $error("power stage on after transient fault");
  AST_FLAG: assert property (@(posedge mclk_in) disable iff (rst_in)
    trip_active_flag_out == (latch != 8'h00))
    else $error("trip flag disagrees with latch");
  AST_CODE: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && new_trip |=> first_code_out == $past(code_of(cond)))
    else $error("first code not the trip id");
  AST_FLASH: assert property (@(posedge mclk_in) disable iff (rst_in)
    !trip_active_flag_out |-> indicator_a_out)
    else $error("indicator not steady while healthy");
  AST_NO_CLR: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && trip_active_flag_out && cond != 8'h00 |=> trip_active_flag_out)
    else $error("trip cleared with fault present");
  AST_STOP_CLR: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && pin_rise[ptlm_pkg::S_STOP] && cond == 8'h00
    |=> !trip_active_flag_out && first_code_out == 4'h0)
    else $error("stop did not clear the trip");
  AST_EXT: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && !ctrl[ptlm_pkg::CTRL_EXTDIS] && !pins.clean[ptlm_pkg::S_EXT]
    |=> latch[ptlm_pkg::F_EXT])
    else $error("external trip not latched");
  AST_FIRST: assert property (@(posedge mclk_in) disable iff (rst_in)
    ce_in && trip_active_flag_out && !clr_ok |=> $stable(first_code_out))
    else $error("first code overwritten");
endmodule
`default_nettype wire

// ==== design/ptlm_pkg.sv ====
// Functional notes
// - Any trip drops the power stage enable at once so the motor coasts.
// - Every trip is held in a latch until an explicit reset action.
// - The latch and the disabled power stage stay put after a transient fault goes away.
// - While any trip is latched the trip-active flag is high.
// - A new trip places its numeric identifier in the first-fault code.
// - While trip_active_flag the indicator_a indicator flashes and the cause is shown to the keypad.
// - Stop acknowledges the trip message and escape dismisses it.
// - A reset request is ignored while a fault condition is still active.
// - With faults gone, stop clears the trip and a later run command may restart.
// - Enable driven low then high clears the trip when faults are gone.
// - The external trip is raised when its terminal is not high, unless the mode disables it.
// - The inverse-time trip is raised after 150 percent load is held for 60 seconds.
// - The stall trip is raised when a stall lasts past the programmed duration.
// - The keypad-loss trip is raised when the keypad is lost while running in local control.
// - The link-loss trip is raised when the command word is not rewritten within the timeout.
package ptlm_pkg;
  // ******************************
  // Register map
  // ******************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STALL = 8'h04;
  localparam logic [7:0] OFS_LINK = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  // Control fields and reset values
  localparam int CTRL_EXTDIS = 0;
  localparam int CTRL_LOCAL = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [15:0] STALL_RST = 16'h03e8;
  localparam logic [15:0] LINK_RST = 16'h0000;
  // Status fields
  localparam int ST_CODE = 4;
  localparam int ST_LATCH = 8;
  localparam int ST_COND = 16;
  localparam int ST_PWR = 24;
  // Interrupt bits
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_CLR = 1;
  // ******************************
  // Fault sources, code = index + 1
  // ******************************
  localparam int NF = 8;
  localparam int F_EXT = 0;
  localparam int F_IT = 1;
  localparam int F_STALL = 2;
  localparam int F_KPAD = 3;
  localparam int F_LINK = 4;
  localparam int F_OVOLT = 5;
  localparam int F_UVOLT = 6;
  localparam int F_OTEMP = 7;
  // Synchronised pins
  localparam int NS = 6;
  localparam int S_EXT = 0;
  localparam int S_EN = 1;
  localparam int S_STOP = 2;
  localparam int S_ESC = 3;
  localparam int S_KPAD = 4;
  localparam int S_RUN = 5;
  // Idle pin levels: ext terminal healthy, enable high, keypad present
  localparam logic [NS-1:0] PIN_IDLE = 6'h13;
  // ******************************
  // Timing
  // ******************************
  localparam int CLK_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam logic [15:0] IT_MS = 16'd60000;
  localparam logic [15:0] FLASH_MS = 16'd250;
endpackage

// ==== design/ptlm_sync_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// ******************************
// Raw pins and their clean copies
// ******************************
interface ptlm_sync_if #(parameter int N = 1);
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  modport src(output raw, input clean);
  modport snk(input raw, output clean);
endinterface
`default_nettype wire

// ==== design/ptlm_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// ******************************
// Three-stage pin synchroniser
// ******************************
module ptlm_sync #(parameter int N = 1, parameter logic [N-1:0] RST_VAL = '0) (
  // Clock, reset, enable
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Pins
  ptlm_sync_if.snk s
);
  logic [N-1:0] st1;
  logic [N-1:0] st2;
  logic [N-1:0] st3;
  logic [N-1:0] q;
  genvar i;
  // Change accepted once stages two and three agree
  // Stages reset to the idle pin level, so no false edge or trip follows reset
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge mclk_in) begin
        if (rst_in) begin
          st1[i] <= RST_VAL[i];
          st2[i] <= RST_VAL[i];
          st3[i] <= RST_VAL[i];
          q[i] <= RST_VAL[i];
        end else if (ce_in) begin
          st1[i] <= s.raw[i];
          st2[i] <= st1[i];
          st3[i] <= st2[i];
          if (st2[i] == st3[i]) begin
            q[i] <= st3[i];
          end
        end
      end
    end
  endgenerate
  assign s.clean = q;
endmodule
`default_nettype wire

// ==== dv/ptlm_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// ******************************
// Keypad, terminals and remote command master
// ******************************
module ptlm_partner (
  // Clock
  input wire logic mclk_in,
  // AHB-Lite master side
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  // Terminal and keypad pins, indexed as the synchroniser slots
  output logic [5:0] pins_out
);
  // Idle bus, ext terminal healthy, enable high, keypad present
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = 3'h2;
    hwdata_out = 32'h0;
    pins_out = 6'h13;
  end

  // Bounded wait for hready at a rising edge
  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge mclk_in);
      i++;
    end while (hready_in !== 1'b1 && i < 100);
    if (hready_in !== 1'b1) begin
      tb_top.err_count++;
      tb_top.report_and_stop();
    end
  endtask

  // One single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk_in);
    hsel_out <= 1'b1;
    haddr_out <= {24'h0, a};
    htrans_out <= 2'h2;
    hwrite_out <= wr;
    wait_ready();
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= wd;
    wait_ready();
    rd = hrdata_in;
    // Released lines carry no stale value
    hwdata_out <= ~wd;
    haddr_out <= ~{24'h0, a};
  endtask

  // Pin change, then time for the three-stage synchroniser
  task automatic pin(input int idx, input logic v);
    @(posedge mclk_in);
    pins_out[idx] <= v;
    repeat (8) @(posedge mclk_in);
  endtask

  // Key press and release
  task automatic press(input int idx);
    pin(idx, 1'b1);
    pin(idx, 1'b0);
  endtask

  // Enable driven low then high as a reset request
  task automatic toggle_enable();
    pin(ptlm_pkg::S_EN, 1'b0);
    pin(ptlm_pkg::S_EN, 1'b1);
  endtask

  // Remote master rewrites the command word
  task automatic refresh();
    logic [31:0] d;
    bus(1'b1, ptlm_pkg::OFS_CMD, 32'h0000a5c3, d);
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ******************************
  // Signals
  // ******************************
  localparam int MSC = 10;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] flt = 5'h0; // Overload, stall, overvolt, undervolt, overtemp
  logic hsel, hwrite, hrdy, hresp, pwr, flag, ind, msg, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [5:0] pins;
  logic [3:0] code, cause;
  int err_count = 0;
  int compares = 0;

  // Clock of 100 ns period
  always #50 mclk_in = ~mclk_in;

  // Far side model and device
  ptlm_partner p (.mclk_in(mclk_in), .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
    .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata), .hready_in(hrdy),
    .hrdata_in(hrdata), .pins_out(pins));
  ptlm_top #(.MS_CYCLES(MSC)) uut (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'b1),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
    .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(hresp), .ext_trip_pin_in(pins[0]), .enable_pin_in(pins[1]),
    .stop_key_in(pins[2]), .esc_key_in(pins[3]), .keypad_present_in(pins[4]),
    .run_pin_in(pins[5]), .overload_in(flt[0]), .stall_in(flt[1]), .overvolt_in(flt[2]),
    .undervolt_in(flt[3]), .overtemp_in(flt[4]), .power_enable_out(pwr),
    .trip_active_flag_out(flag), .first_code_out(code), .indicator_a_out(ind),
    .keypad_msg_out(msg), .keypad_cause_out(cause), .irq_out(irq));

  // ******************************
  // Helpers
  // ******************************
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Same-clock fault level change, settled one edge later
  task automatic setf(input int i, input logic v);
    @(posedge mclk_in);
    flt[i] <= v;
    repeat (2) @(posedge mclk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    p.bus(1'b1, a, d, rd);
  endtask

  task automatic rdr(input logic [7:0] a);
    p.bus(1'b0, a, 32'h0, rd);
  endtask

  task automatic wait_trip(input int lim);
    int i;
    i = 0;
    while (flag !== 1'b1 && i < lim) begin
      @(posedge mclk_in);
      i++;
    end
    if (flag !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic run_on();
    p.pin(ptlm_pkg::S_RUN, 1'b1);
    chk("power_on", pwr, 1);
  endtask

  task automatic stop_clear();
    p.press(ptlm_pkg::S_STOP);
    chk("flag_clear", flag, 0);
    chk("code_clear", code, 0);
  endtask

  // ******************************
  // Scenarios
  // ******************************
  task automatic t_reset();
    chk("hready", hrdy, 1);
    chk("hresp", hresp, 0);
    chk("flag_reset", flag, 0);
    chk("power_reset", pwr, 0);
    chk("indicator", ind, 1);
    rdr(ptlm_pkg::OFS_STALL);
    chk("stall_reg", rd, 32'h3e8);
    rdr(ptlm_pkg::OFS_LINK);
    chk("link_reg", rd, 32'h0);
    rdr(8'h40);
    chk("unmapped", rd, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_latch();
    run_on();
    setf(2, 1'b1);
    setf(2, 1'b0);
    chk("power_off", pwr, 0);
    chk("flag_held", flag, 1);
    chk("code", code, 6);
    chk("cause", cause, 6);
    chk("msg", msg, 1);
    rdr(ptlm_pkg::OFS_STAT);
    chk("status", rd & 32'h010000f1, 32'h61);
    rdr(ptlm_pkg::OFS_IRQ);
    chk("irq_new", rd, 32'h1);
    wr(ptlm_pkg::OFS_MASK, 32'h0);
    repeat (2) @(posedge mclk_in);
    chk("irq_masked", irq, 0);
    wr(ptlm_pkg::OFS_MASK, 32'h3);
    repeat (2) @(posedge mclk_in);
    chk("irq_mask", irq, 1);
    setf(3, 1'b1);
    chk("code_kept", code, 6);
    p.press(ptlm_pkg::S_STOP);
    chk("refused", flag, 1);
    chk("msg_ack", msg, 0);
    setf(3, 1'b0);
    wr(ptlm_pkg::OFS_IRQ, 32'h1);
    stop_clear();
    rdr(ptlm_pkg::OFS_IRQ);
    chk("irq_cleared", rd, 32'h2);
    wr(ptlm_pkg::OFS_IRQ, 32'h3);
    rdr(ptlm_pkg::OFS_IRQ);
    chk("irq_w1c", rd, 32'h0);
    chk("irq_low", irq, 0);
    chk("power_stays", pwr, 0);
    p.pin(ptlm_pkg::S_RUN, 1'b0);
    run_on();
    p.pin(ptlm_pkg::S_RUN, 1'b0);
    $display("test latch done");
  endtask

  task automatic t_flash();
    logic v;
    int n;
    setf(4, 1'b1);
    setf(4, 1'b0);
    for (int k = 0; k < 2; k++) begin
      v = ind;
      n = 0;
      while (ind === v && n < 3000) begin
        @(posedge mclk_in);
        n++;
      end
    end
    chk("flash_period", n, ptlm_pkg::FLASH_MS * MSC);
    p.press(ptlm_pkg::S_ESC);
    chk("msg_esc", msg, 0);
    p.toggle_enable();
    chk("enable_reset", flag, 0);
    chk("lamp_steady", ind, 1);
    $display("test flash done");
  endtask

  task automatic t_ext();
    p.pin(ptlm_pkg::S_EXT, 1'b0);
    chk("ext_trip", code, 1);
    p.pin(ptlm_pkg::S_EXT, 1'b1);
    stop_clear();
    wr(ptlm_pkg::OFS_CTRL, 32'h1);
    p.pin(ptlm_pkg::S_EXT, 1'b0);
    chk("ext_masked", flag, 0);
    p.pin(ptlm_pkg::S_EXT, 1'b1);
    wr(ptlm_pkg::OFS_CTRL, 32'h2);
    run_on();
    p.pin(ptlm_pkg::S_KPAD, 1'b0);
    chk("kpad_trip", code, 4);
    p.pin(ptlm_pkg::S_KPAD, 1'b1);
    wr(ptlm_pkg::OFS_CTRL, 32'h0);
    stop_clear();
    p.pin(ptlm_pkg::S_RUN, 1'b0);
    $display("test ext and keypad done");
  endtask

  task automatic t_timers();
    setf(0, 1'b1);
    repeat (50) @(posedge mclk_in);
    chk("it_short", flag, 0);
    setf(0, 1'b0);
    wr(ptlm_pkg::OFS_STALL, 32'h2);
    @(posedge mclk_in);
    flt[1] <= 1'b1;
    repeat (12) @(posedge mclk_in);
    chk("stall_early", flag, 0);
    wait_trip(40);
    chk("stall_code", code, 3);
    setf(1, 1'b0);
    stop_clear();
    // Fresh command word before the timeout is armed
    p.refresh();
    wr(ptlm_pkg::OFS_LINK, 32'h3);
    repeat (5) begin
      repeat (10) @(posedge mclk_in);
      p.refresh();
    end
    chk("link_fed", flag, 0);
    wait_trip(60);
    chk("link_code", code, 5);
    wr(ptlm_pkg::OFS_LINK, 32'h0);
    p.refresh();
    stop_clear();
    $display("test timers done");
  endtask

  // ******************************
  // Main sequence
  // ******************************
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    t_reset();
    t_latch();
    t_flash();
    t_ext();
    t_timers();
    report_and_stop();
  end
endmodule
`default_nettype wire
